// ===== test/dpio_chk.sv
// ====
// port-level checker
module dpio_chk (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic [1:0] op_mode_i,
   input wire logic has_ext_bus_i,
   input wire logic pwm2_pin_remap_i,
   input wire logic enhanced_pwm_pin_remap_i,
   input wire logic [7:0] port_e_in_i,
   input wire logic [7:0] port_e_oe_o,
   input wire logic [7:0] port_f_in_i,
   input wire logic [7:0] port_f_oe_o,
   input wire logic [7:0] ext_bus_hi_in_o,
   input wire logic slave_port_read_o,
   input wire logic slave_port_write_o,
   input wire logic pwm2_on_port_c_o,
   input wire logic pwm2_on_port_b_o,
   input wire logic epwm_on_port_h_o,
   input wire logic spi_slave_select_n_o,
   input wire logic [7:0] port_f_analog_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);

   one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("waitrequest held past one wait state");
   idle_nowait_a: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("waitrequest without request");
   rdata_hold_a: assert property (!avs_read_i |=> $stable(avs_readdata_o))
      else $error("read data moved without read");
   rdata_hi_a: assert property (avs_readdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   sp_read_a: assert property (slave_port_read_o |-> op_mode_i == 2'h0 && !port_e_in_i[2] && !port_e_in_i[0])
      else $error("read strobe without select and read low");
   sp_write_a: assert property (slave_port_write_o |-> op_mode_i == 2'h0 && !port_e_in_i[2] && !port_e_in_i[1])
      else $error("write strobe without select and write low");
   sp_pins_in_a: assert property (slave_port_read_o || slave_port_write_o |-> port_e_oe_o[2:0] == 3'h0)
      else $error("strobe pins driven");
   ss_pin_a: assert property (spi_slave_select_n_o == port_f_in_i[7])
      else $error("slave select not from pin 7");
   bus_in_a: assert property (ext_bus_hi_in_o == port_e_in_i)
      else $error("bus high byte input mismatch");
   pwm2_map_a: assert property (pwm2_on_port_c_o == pwm2_pin_remap_i
      && pwm2_on_port_b_o == (!pwm2_pin_remap_i && op_mode_i != 2'h0))
      else $error("channel 2 pin choice wrong");
   epwm_map_a: assert property (epwm_on_port_h_o == (has_ext_bus_i && !enhanced_pwm_pin_remap_i))
      else $error("enhanced pwm port choice wrong");
   analog_off_a: assert property ((port_f_analog_o & port_f_oe_o) == 8'h00)
      else $error("analog pin driven");

   cover property (avs_read_i && !avs_waitrequest_o);
   cover property (avs_write_i && !avs_waitrequest_o);
   cover property (slave_port_read_o);
   cover property (slave_port_write_o);
endmodule // dpio_chk

bind dpio_top dpio_chk u_chk (.ref_clk_i, .resetn_i, .avs_read_i, .avs_write_i, .avs_readdata_o,
   .avs_waitrequest_o, .op_mode_i, .has_ext_bus_i, .pwm2_pin_remap_i, .enhanced_pwm_pin_remap_i, .port_e_in_i,
   .port_e_oe_o, .port_f_in_i, .port_f_oe_o, .ext_bus_hi_in_o, .slave_port_read_o, .slave_port_write_o,
   .pwm2_on_port_c_o, .pwm2_on_port_b_o, .epwm_on_port_h_o, .spi_slave_select_n_o, .port_f_analog_o);

// ===== test/dpio_host.sv
// ====
// external host on the strobe pins
module dpio_host (
   input wire logic [2:0] strobe_n_i,
   input wire logic [7:0] idle_i,
   input wire logic [7:0] dut_out_i,
   input wire logic [7:0] dut_oe_i,
   output logic [7:0] pin_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] host_drive;

   always_comb
   begin
      host_drive = idle_i;
      host_drive[2:0] = strobe_n_i;
   end
   assign pin_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & host_drive);
endmodule // dpio_host

// ===== test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} dpio_row_type;
   logic clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, bus_drv = 1'b0, has_bus = 1'b1;
   logic p2remap = 1'b0, eremap = 1'b1, p2a = 1'b0, p2a_en = 1'b0, c1 = 1'b0, c2 = 1'b0;
   logic [5:0] addr = 6'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] be = 4'hF, epwm_en = 4'h0, pw = 4'h9;
   logic [2:0] status = 3'h5, strobe_n = 3'h7;
   logic [1:0] mode = 2'h0;
   logic [7:0] e_ext = 8'h00, f_ext = 8'hFF, bus_out = 8'h96, q;
   logic [7:0] e_pin, e_out, e_oe, f_pin, f_out, f_oe, bus_in, f_an;
   logic waitreq, sp_rd, sp_wr, ecc2, p2c, p2b, eph, cref, ss_n;
   int num_errors = 0, tests_run = 0, cyc = 0;
   dpio_row_type rows [0:9] = '{
      '{dpio_pkg::OFS_PORT_E_DIRECTION, 8'h5A, 8'h5A},
      '{dpio_pkg::OFS_PORT_E_PINS, 8'h3C, 8'h26},
      '{dpio_pkg::OFS_PORT_E_LATCH, 8'hC3, 8'hC3},
      '{dpio_pkg::OFS_EXT_BUS_CONTROL, 8'hFF, 8'hB3},
      '{dpio_pkg::OFS_COMPARATOR_CONTROL, 8'h07, 8'h07},
      '{dpio_pkg::OFS_ANALOG_PIN_CONFIG, 8'hFF, 8'h3F},
      '{dpio_pkg::OFS_PORT_F_DIRECTION, 8'hCF, 8'hCF},
      '{dpio_pkg::OFS_PORT_F_LATCH, 8'hA5, 8'hA5},
      '{dpio_pkg::OFS_PORT_F_PINS, 8'h5A, 8'hDF},
      '{6'h3C, 8'hFF, 8'h00}};

   dpio_top u_dut (
      .ref_clk_i(clk), .resetn_i(rstn), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
      .op_mode_i(mode), .has_ext_bus_i(has_bus), .pwm2_pin_remap_i(p2remap), .enhanced_pwm_pin_remap_i(eremap),
      .port_e_in_i(e_pin), .port_e_out_o(e_out), .port_e_oe_o(e_oe), .port_f_in_i(f_pin),
      .port_f_out_o(f_out), .port_f_oe_o(f_oe), .ext_bus_hi_out_i(bus_out), .ext_bus_hi_drive_i(bus_drv),
      .ext_bus_hi_in_o(bus_in), .slave_port_status_i(status), .slave_port_read_o(sp_rd),
      .slave_port_write_o(sp_wr), .pwm2_output_a_i(p2a), .pwm2_output_a_en_i(p2a_en),
      .enhanced_capture_channel_2_o(ecc2), .pwm2_on_port_c_o(p2c), .pwm2_on_port_b_o(p2b),
      .pwm1_output_b_i(pw[3]), .pwm1_output_c_i(pw[2]), .pwm3_output_b_i(pw[1]), .pwm3_output_c_i(pw[0]),
      .epwm_en_i(epwm_en), .epwm_on_port_h_o(eph), .comparator1_output_i(c1), .comparator2_output_i(c2),
      .comparator_reference_out_o(cref), .spi_slave_select_n_o(ss_n), .port_f_analog_o(f_an));
   dpio_host u_host (.strobe_n_i(strobe_n), .idle_i(e_ext), .dut_out_i(e_out), .dut_oe_i(e_oe), .pin_o(e_pin));
   assign f_pin = (f_oe & f_out) | (~f_oe & f_ext);

   initial
   begin
      forever #5 clk = ~clk;
   end

   // ====
   // bus and compare tasks
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, output logic [7:0] r);
      @(posedge clk);
      addr <= a;
      wdata <= {24'h0, d};
      rd <= !w;
      wr <= w;
      @(posedge clk);
      // wait for the answer; only the bench timeout ends a hang
      while (waitreq !== 1'b0)
      begin
         @(posedge clk);
      end
      r = rdata[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk1(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic rchk(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] r;
      bus(1'b0, a, 8'h00, r);
      chk8($sformatf("reg %h", a), e, r);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         wrap_up();
      end
   end

   // ====
   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      rchk(dpio_pkg::OFS_PORT_E_DIRECTION, 8'hFF);
      rchk(dpio_pkg::OFS_PORT_F_DIRECTION, 8'hFF);
      rchk(dpio_pkg::OFS_PORT_F_PINS, 8'h80);
      chk8("e_oe", 8'h00, e_oe);
      chk8("f_analog", 8'h7F, f_an);
      foreach (rows[i])
      begin
         bus(1'b1, rows[i].a, rows[i].d, q);
         rchk(rows[i].a, rows[i].e);
      end
      chk8("e_oe", 8'hA5, e_oe);
      chk8("e_out", 8'h81, e_out & e_oe);
      chk8("f_oe", 8'h30, f_oe);
      // write with lane 0 disabled is ignored
      be <= 4'hE;
      bus(1'b1, dpio_pkg::OFS_PORT_F_LATCH, 8'h11, q);
      be <= 4'hF;
      rchk(dpio_pkg::OFS_PORT_F_LATCH, 8'h5A);
      // slave port strobes
      bus(1'b1, dpio_pkg::OFS_PORT_E_DIRECTION, 8'h07, q);
      bus(1'b1, dpio_pkg::OFS_SLAVE_PORT_CONTROL, 8'hFF, q);
      rchk(dpio_pkg::OFS_SLAVE_PORT_CONTROL, 8'hB0);
      strobe_n <= 3'h2;
      @(posedge clk);
      chk1("sp_read", 1'b1, sp_rd);
      chk1("sp_write", 1'b0, sp_wr);
      strobe_n <= 3'h1;
      @(posedge clk);
      chk1("sp_write", 1'b1, sp_wr);
      chk1("sp_read", 1'b0, sp_rd);
      strobe_n <= 3'h4;
      @(posedge clk);
      chk1("sp_idle", 1'b0, sp_rd | sp_wr);
      strobe_n <= 3'h7;
      bus(1'b1, dpio_pkg::OFS_SLAVE_PORT_CONTROL, 8'h00, q);
      // external bus takes port E
      mode <= 2'h1;
      bus_drv <= 1'b1;
      bus(1'b1, dpio_pkg::OFS_EXT_BUS_CONTROL, 8'h00, q);
      @(posedge clk);
      chk8("e_oe", 8'hFF, e_oe);
      chk8("e_out", 8'h96, e_out);
      chk8("bus_in", 8'h96, bus_in);
      chk1("p2b", 1'b1, p2b);
      rchk(dpio_pkg::OFS_PORT_E_DIRECTION, 8'h07);
      bus(1'b1, dpio_pkg::OFS_EXT_BUS_CONTROL, 8'h80, q);
      @(posedge clk);
      chk8("e_oe", 8'hF8, e_oe);
      mode <= 2'h0;
      bus_drv <= 1'b0;
      // pwm pins on port E
      bus(1'b1, dpio_pkg::OFS_PORT_E_DIRECTION, 8'hFF, q);
      p2a_en <= 1'b1;
      p2a <= 1'b1;
      epwm_en <= 4'hF;
      @(posedge clk);
      chk8("e_oe", 8'hF8, e_oe);
      chk8("e_out", 8'hC8, e_out & 8'hF8);
      chk1("ecc2", 1'b1, ecc2);
      pw <= 4'h6;
      p2remap <= 1'b1;
      @(posedge clk);
      chk8("e_oe", 8'h78, e_oe);
      chk8("e_out", 8'h30, e_out & 8'h78);
      chk1("p2c", 1'b1, p2c);
      chk1("ecc2", 1'b0, ecc2);
      eremap <= 1'b0;
      @(posedge clk);
      chk8("e_oe", 8'h00, e_oe);
      chk1("eph", 1'b1, eph);
      has_bus <= 1'b0;
      @(posedge clk);
      chk8("e_oe", 8'h78, e_oe);
      has_bus <= 1'b1;
      epwm_en <= 4'h0;
      p2a_en <= 1'b0;
      // comparator outputs and reference
      c1 <= 1'b1;
      bus(1'b1, dpio_pkg::OFS_COMPARATOR_CONTROL, 8'h03, q);
      bus(1'b1, dpio_pkg::OFS_PORT_F_DIRECTION, 8'h00, q);
      bus(1'b1, dpio_pkg::OFS_COMPARATOR_VREF_CONTROL, 8'hC0, q);
      @(posedge clk);
      chk8("f_analog", 8'h78, f_an);
      chk8("f_cmp_out", 8'h04, f_out & 8'h06);
      chk1("cref", 1'b1, cref);
      chk1("ss_n", 1'b0, ss_n);
      rchk(dpio_pkg::OFS_COMPARATOR_CONTROL, 8'h43);
      // second reset in extended mode
      mode <= 2'h2;
      bus_drv <= 1'b1;
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rchk(dpio_pkg::OFS_EXT_BUS_CONTROL, 8'h00);
      chk8("e_oe", 8'hFF, e_oe);
      rchk(dpio_pkg::OFS_PORT_F_DIRECTION, 8'hFF);
      wrap_up();
   end
endmodule // tb_top

// ===== verilog/dpio_pkg.sv
package dpio_pkg;

   // ==========================================================
   // register byte offsets
   // ==========================================================
   localparam logic [5:0] OFS_PORT_E_DIRECTION = 6'h00;
   localparam logic [5:0] OFS_PORT_E_PINS = 6'h04;
   localparam logic [5:0] OFS_PORT_E_LATCH = 6'h08;
   localparam logic [5:0] OFS_EXT_BUS_CONTROL = 6'h0C;
   localparam logic [5:0] OFS_SLAVE_PORT_CONTROL = 6'h10;
   localparam logic [5:0] OFS_PORT_F_DIRECTION = 6'h14;
   localparam logic [5:0] OFS_PORT_F_PINS = 6'h18;
   localparam logic [5:0] OFS_PORT_F_LATCH = 6'h1C;
   localparam logic [5:0] OFS_ANALOG_PIN_CONFIG = 6'h20;
   localparam logic [5:0] OFS_COMPARATOR_CONTROL = 6'h24;
   localparam logic [5:0] OFS_COMPARATOR_VREF_CONTROL = 6'h28;

   // ==========================================================
   // reset values
   // ==========================================================
   localparam logic [7:0] RST_DIRECTION = 8'hFF;
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_CONTROL = 8'h00;

   // ==========================================================
   // field positions and masks
   // ==========================================================
   localparam int EXT_BUS_DISABLE_BIT = 7;
   localparam logic [7:0] EXT_BUS_CONTROL_MASK = 8'hB3;
   localparam int SLAVE_PORT_ENABLE_BIT = 4;
   localparam logic [7:0] ANALOG_PIN_CONFIG_MASK = 8'h3F;
   localparam int COMPARATOR_MODE_LSB = 0;
   localparam logic [2:0] COMPARATOR_MODE_OFF = 3'h7;
   localparam logic [2:0] COMPARATOR_MODE_OUTPUTS = 3'h3;
   localparam int VREF_ENABLE_BIT = 7;
   localparam int VREF_OUTPUT_BIT = 6;
   localparam logic [4:0] ANALOG_CHANNEL_LIMIT = 5'h0F;
   localparam logic [4:0] PORT_F_FIRST_CHANNEL = 5'h05;
   localparam int PORT_F_ANALOG_PINS = 7;
   localparam logic [7:0] PORT_F_COMPARATOR_INPUTS = 8'h78;
   localparam int PIN_COMPARATOR2_OUT = 1;
   localparam int PIN_COMPARATOR1_OUT = 2;
   localparam int PIN_VREF_OUT = 5;
   localparam int PIN_SLAVE_SELECT = 7;
   localparam int PIN_SP_READ = 0;
   localparam int PIN_SP_WRITE = 1;
   localparam int PIN_SP_SELECT = 2;
   localparam logic [7:0] SLAVE_PORT_PINS = 8'h07;
   localparam logic [7:0] EPWM_PINS = 8'h78;
   localparam int PIN_PWM2 = 7;

   // ==========================================================
   // operating modes
   // ==========================================================
   typedef enum logic [1:0] {
      DPIO_MICROCONTROLLER = 2'b00,
      DPIO_MICROPROCESSOR = 2'b01,
      DPIO_EXTENDED_MICROCONTROLLER = 2'b10,
      DPIO_MODE_RESERVED = 2'b11
   } dpio_mode_type;

endpackage // dpio_pkg

// ===== verilog/dpio_top.sv
// Notes on behaviour
// RQ1 - direction 1 tristates pin, 0 drives latch
// RQ2 - latch register reads back stored latch
// RQ3 - port read gives pins, write loads latch
// RQ4 - port E is I/O only when bus disabled
// RQ5 - bus modes put address/data 15:8 on E
// RQ6 - slave-port enable turns E2:0 into strobes
// RQ7 - software sets E2:0 input and digital first
// RQ8 - low read with select presents port D
// RQ9 - low write with select writes port D
// RQ10 - select low enables slave-port transfers
// RQ11 - remap clear puts channel 2 on E7
// RQ12 - enhanced PWM B/C outputs on E6:E3
// RQ13 - channel 2 on C1 or B3 otherwise
// RQ14 - 80-pin extended mode starts on system bus
// RQ15 - direction registers reset to all inputs
// RQ16 - port F analog pins read zero after reset
// RQ17 - software disables comparators, sets analog config
// RQ18 - F7 slave select, comparator and reference outputs
// RQ19 - overrides never alter stored direction bits
// RQ20 - analog pins read zero and never drive
//
// Our own choices: the register offsets and the Avalon-MM register port.
module dpio_top (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [1:0] op_mode_i,
   input wire logic has_ext_bus_i,
   input wire logic pwm2_pin_remap_i,
   input wire logic enhanced_pwm_pin_remap_i,
   input wire logic [7:0] port_e_in_i,
   output logic [7:0] port_e_out_o,
   output logic [7:0] port_e_oe_o,
   input wire logic [7:0] port_f_in_i,
   output logic [7:0] port_f_out_o,
   output logic [7:0] port_f_oe_o,
   input wire logic [7:0] ext_bus_hi_out_i,
   input wire logic ext_bus_hi_drive_i,
   output logic [7:0] ext_bus_hi_in_o,
   input wire logic [2:0] slave_port_status_i,
   output logic slave_port_read_o,
   output logic slave_port_write_o,
   input wire logic pwm2_output_a_i,
   input wire logic pwm2_output_a_en_i,
   output logic enhanced_capture_channel_2_o,
   output logic pwm2_on_port_c_o,
   output logic pwm2_on_port_b_o,
   input wire logic pwm1_output_b_i,
   input wire logic pwm1_output_c_i,
   input wire logic pwm3_output_b_i,
   input wire logic pwm3_output_c_i,
   input wire logic [3:0] epwm_en_i,
   output logic epwm_on_port_h_o,
   input wire logic comparator1_output_i,
   input wire logic comparator2_output_i,
   output logic comparator_reference_out_o,
   output logic spi_slave_select_n_o,
   output logic [7:0] port_f_analog_o
);

   // ==========================================================
   // registers and bus handshake signals
   // ==========================================================
   logic [7:0] port_e_direction;
   logic [7:0] port_e_latch;
   logic [7:0] ext_bus_control;
   logic [7:0] slave_port_control;
   logic [7:0] port_f_direction;
   logic [7:0] port_f_latch;
   logic [7:0] analog_pin_config;
   logic [7:0] comparator_control;
   logic [7:0] comparator_vref_control;
   logic bus_ack;
   logic [7:0] next_rdata;
   logic bus_req;
   logic wr_take;
   logic wr_lane;

   // ==========================================================
   // pin mode decode
   // ==========================================================
   dpio_pkg::dpio_mode_type mode;
   logic mcu_mode;
   logic ext_bus_active;
   logic slave_port_active;
   logic pwm2_on_e7;
   logic epwm_on_e;
   logic comparators_on;
   logic [2:0] comp_mode;
   logic [7:0] f_analog;
   logic [7:0] port_f_read;
   logic [7:0] e_out_mux;
   logic [7:0] e_oe_mux;
   logic [7:0] f_out_mux;
   logic [7:0] f_oe_mux;
   logic [7:0] epwm_out;
   logic [7:0] epwm_oe;

   assign mode = dpio_pkg::dpio_mode_type'(op_mode_i);
   assign mcu_mode = (mode == dpio_pkg::DPIO_MICROCONTROLLER);
   // with has_ext_bus_i set and outside microcontroller mode, bus owns port E until software disables it; holds at reset since the disable bit clears
   assign ext_bus_active = has_ext_bus_i & ~mcu_mode
      & ~ext_bus_control[dpio_pkg::EXT_BUS_DISABLE_BIT]; // [RQ4] [RQ5] [RQ14]
   assign slave_port_active = mcu_mode
      & slave_port_control[dpio_pkg::SLAVE_PORT_ENABLE_BIT]; // [RQ6]
   assign pwm2_on_e7 = mcu_mode & ~pwm2_pin_remap_i; // [RQ11]
   assign pwm2_on_port_c_o = pwm2_pin_remap_i; // [RQ13]
   assign pwm2_on_port_b_o = ~pwm2_pin_remap_i & ~mcu_mode; // [RQ13]
   assign epwm_on_e = ~has_ext_bus_i | enhanced_pwm_pin_remap_i; // [RQ12]
   assign epwm_on_port_h_o = ~epwm_on_e; // [RQ12]
   assign comp_mode = comparator_control[dpio_pkg::COMPARATOR_MODE_LSB +: 3];
   assign comparators_on = (comp_mode != dpio_pkg::COMPARATOR_MODE_OFF);

   // enhanced PWM B/C outputs on E6..E3
   assign epwm_out = {1'b0, pwm1_output_b_i, pwm1_output_c_i, pwm3_output_b_i, pwm3_output_c_i, 3'h0};
   assign epwm_oe = {1'b0, epwm_en_i, 3'h0} & dpio_pkg::EPWM_PINS;

   // analog pin map: channel k is analog while k + config < limit
   always_comb
   begin
      f_analog = 8'h00;
      for (int n = 0; n < dpio_pkg::PORT_F_ANALOG_PINS; n++)
      begin
         f_analog[n] = ((dpio_pkg::PORT_F_FIRST_CHANNEL + 5'(n) + {1'b0, analog_pin_config[3:0]})
            < dpio_pkg::ANALOG_CHANNEL_LIMIT); // [RQ20]
      end
      if (comparators_on)
      begin
         f_analog = f_analog | dpio_pkg::PORT_F_COMPARATOR_INPUTS; // [RQ20]
      end
   end
   assign port_f_analog_o = f_analog;

   // ==========================================================
   // port E pin multiplexer
   // ==========================================================
   always_comb
   begin
      e_out_mux = port_e_latch;
      e_oe_mux = ~port_e_direction; // [RQ1]
      if (ext_bus_active)
      begin
         e_out_mux = ext_bus_hi_out_i; // [RQ5]
         e_oe_mux = {8{ext_bus_hi_drive_i}}; // [RQ5]
      end
      else
      begin
         if (epwm_on_e)
         begin
            e_out_mux = (e_out_mux & ~epwm_oe) | (epwm_out & epwm_oe); // [RQ12]
            e_oe_mux = e_oe_mux | epwm_oe; // [RQ12]
         end
         if (pwm2_on_e7 & pwm2_output_a_en_i)
         begin
            e_out_mux[dpio_pkg::PIN_PWM2] = pwm2_output_a_i; // [RQ11]
            e_oe_mux[dpio_pkg::PIN_PWM2] = 1'b1; // [RQ11]
         end
         if (slave_port_active)
         begin
            e_oe_mux = e_oe_mux & ~dpio_pkg::SLAVE_PORT_PINS; // [RQ6] [RQ19]
         end
      end
   end
   assign port_e_out_o = e_out_mux;
   assign port_e_oe_o = e_oe_mux;
   assign ext_bus_hi_in_o = port_e_in_i; // [RQ5]
   assign enhanced_capture_channel_2_o = pwm2_on_e7 & port_e_in_i[dpio_pkg::PIN_PWM2]; // [RQ11]

   // ==========================================================
   // slave-port strobes
   // ==========================================================
   always_comb
   begin
      slave_port_read_o = slave_port_active & ~port_e_in_i[dpio_pkg::PIN_SP_SELECT]
         & ~port_e_in_i[dpio_pkg::PIN_SP_READ]; // [RQ8] [RQ10]
      slave_port_write_o = slave_port_active & ~port_e_in_i[dpio_pkg::PIN_SP_SELECT]
         & ~port_e_in_i[dpio_pkg::PIN_SP_WRITE]; // [RQ9] [RQ10]
   end

   // ==========================================================
   // port F pin multiplexer
   // ==========================================================
   always_comb
   begin
      f_out_mux = port_f_latch;
      f_oe_mux = ~port_f_direction & ~f_analog; // [RQ1] [RQ20]
      if (comp_mode == dpio_pkg::COMPARATOR_MODE_OUTPUTS)
      begin
         f_out_mux[dpio_pkg::PIN_COMPARATOR2_OUT] = comparator2_output_i; // [RQ18]
         f_out_mux[dpio_pkg::PIN_COMPARATOR1_OUT] = comparator1_output_i; // [RQ18]
         f_oe_mux[dpio_pkg::PIN_COMPARATOR2_OUT] = ~f_analog[dpio_pkg::PIN_COMPARATOR2_OUT]; // [RQ20]
         f_oe_mux[dpio_pkg::PIN_COMPARATOR1_OUT] = ~f_analog[dpio_pkg::PIN_COMPARATOR1_OUT]; // [RQ20]
      end
      if (comparator_reference_out_o)
      begin
         f_oe_mux[dpio_pkg::PIN_VREF_OUT] = 1'b0; // [RQ18]
      end
   end
   assign port_f_out_o = f_out_mux;
   assign port_f_oe_o = f_oe_mux;
   assign comparator_reference_out_o = comparator_vref_control[dpio_pkg::VREF_ENABLE_BIT]
      & comparator_vref_control[dpio_pkg::VREF_OUTPUT_BIT]; // [RQ18]
   assign spi_slave_select_n_o = port_f_in_i[dpio_pkg::PIN_SLAVE_SELECT]; // [RQ18]
   assign port_f_read = port_f_in_i & ~f_analog; // [RQ16] [RQ20]

   // ==========================================================
   // Avalon-MM slave: one wait state on every access
   // ==========================================================
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & ~bus_ack;
   assign wr_take = avs_write_i & bus_ack;
   assign wr_lane = wr_take & avs_byteenable_i[0];

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         bus_ack <= 1'b0;
      end
      else
      begin
         bus_ack <= bus_req & ~bus_ack;
      end
   end

   always_comb
   begin
      next_rdata = 8'h00;
      unique case (avs_address_i)
         dpio_pkg::OFS_PORT_E_DIRECTION: next_rdata = port_e_direction; // [RQ19]
         dpio_pkg::OFS_PORT_E_PINS: next_rdata = port_e_in_i; // [RQ3]
         dpio_pkg::OFS_PORT_E_LATCH: next_rdata = port_e_latch; // [RQ2]
         dpio_pkg::OFS_EXT_BUS_CONTROL: next_rdata = has_ext_bus_i ? ext_bus_control : 8'h00;
         dpio_pkg::OFS_SLAVE_PORT_CONTROL: next_rdata = {slave_port_status_i, slave_port_control[4:0]};
         dpio_pkg::OFS_PORT_F_DIRECTION: next_rdata = port_f_direction; // [RQ19]
         dpio_pkg::OFS_PORT_F_PINS: next_rdata = port_f_read; // [RQ3] [RQ16]
         dpio_pkg::OFS_PORT_F_LATCH: next_rdata = port_f_latch; // [RQ2]
         dpio_pkg::OFS_ANALOG_PIN_CONFIG: next_rdata = analog_pin_config;
         dpio_pkg::OFS_COMPARATOR_CONTROL: next_rdata = {comparator2_output_i, comparator1_output_i,
            comparator_control[5:0]};
         dpio_pkg::OFS_COMPARATOR_VREF_CONTROL: next_rdata = comparator_vref_control;
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         avs_readdata_o <= 32'h00000000;
      end
      else if (avs_read_i & ~bus_ack)
      begin
         avs_readdata_o <= {24'h000000, next_rdata};
      end
   end

   // ==========================================================
   // port E registers
   // ==========================================================
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         port_e_direction <= dpio_pkg::RST_DIRECTION; // [RQ15]
      end
      else if (wr_lane & (avs_address_i == dpio_pkg::OFS_PORT_E_DIRECTION))
      begin
         port_e_direction <= avs_writedata_i[7:0]; // [RQ19]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         port_e_latch <= dpio_pkg::RST_LATCH;
      end
      else if (wr_lane & ((avs_address_i == dpio_pkg::OFS_PORT_E_PINS)
         | (avs_address_i == dpio_pkg::OFS_PORT_E_LATCH)))
      begin
         port_e_latch <= avs_writedata_i[7:0]; // [RQ3]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ext_bus_control <= dpio_pkg::RST_CONTROL; // [RQ14]
         slave_port_control <= dpio_pkg::RST_CONTROL;
      end
      else
      begin
         if (wr_lane & (avs_address_i == dpio_pkg::OFS_EXT_BUS_CONTROL))
         begin
            ext_bus_control <= avs_writedata_i[7:0] & dpio_pkg::EXT_BUS_CONTROL_MASK; // [RQ4]
         end
         if (wr_lane & (avs_address_i == dpio_pkg::OFS_SLAVE_PORT_CONTROL))
         begin
            slave_port_control[dpio_pkg::SLAVE_PORT_ENABLE_BIT] <=
               avs_writedata_i[dpio_pkg::SLAVE_PORT_ENABLE_BIT]; // [RQ6]
         end
      end
   end

   // ==========================================================
   // port F and analog registers
   // ==========================================================
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         port_f_direction <= dpio_pkg::RST_DIRECTION; // [RQ15]
      end
      else if (wr_lane & (avs_address_i == dpio_pkg::OFS_PORT_F_DIRECTION))
      begin
         port_f_direction <= avs_writedata_i[7:0]; // [RQ19]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         port_f_latch <= dpio_pkg::RST_LATCH;
      end
      else if (wr_lane & ((avs_address_i == dpio_pkg::OFS_PORT_F_PINS)
         | (avs_address_i == dpio_pkg::OFS_PORT_F_LATCH)))
      begin
         port_f_latch <= avs_writedata_i[7:0]; // [RQ3]
      end
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         analog_pin_config <= dpio_pkg::RST_CONTROL; // [RQ16]
         comparator_control <= dpio_pkg::RST_CONTROL;
         comparator_vref_control <= dpio_pkg::RST_CONTROL;
      end
      else
      begin
         if (wr_lane & (avs_address_i == dpio_pkg::OFS_ANALOG_PIN_CONFIG))
         begin
            analog_pin_config <= avs_writedata_i[7:0] & dpio_pkg::ANALOG_PIN_CONFIG_MASK;
         end
         if (wr_lane & (avs_address_i == dpio_pkg::OFS_COMPARATOR_CONTROL))
         begin
            comparator_control <= {2'b00, avs_writedata_i[5:0]};
         end
         if (wr_lane & (avs_address_i == dpio_pkg::OFS_COMPARATOR_VREF_CONTROL))
         begin
            comparator_vref_control <= avs_writedata_i[7:0];
         end
      end
   end

endmodule // dpio_top
